// >>> drive_err_pkg.sv
/*
  Constants, carrier types and the error code lookup for the drive error
  handling unit. Assumes that fault sources and the master's command path
  reach the unit as plain levels and object accesses.
*/
package drive_err_pkg;

  ////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] OBJ_ERR_WORD = 16'h2320;
  localparam logic [15:0] OBJ_ERR_MASK = 16'h2321;
  localparam logic [15:0] OBJ_COM_RESP = 16'h6007;
  localparam logic [15:0] OBJ_COM_CFG = 16'h2400;
  localparam logic [15:0] OBJ_FAULT_OPT = 16'h605E;
  localparam logic [15:0] OBJ_QS_OPT = 16'h605A;
  localparam logic [7:0] SUB_MAIN = 8'h00;
  localparam logic [7:0] SUB_MON = 8'h04;

  localparam int BIT_SPEED = 0;
  localparam int BIT_TRACK = 1;
  localparam int BIT_OVER = 2;
  localparam int BIT_UNDER = 3;
  localparam int BIT_CLAMP = 4;
  localparam int BIT_THERM = 5;
  localparam int BIT_COM = 11;
  localparam int ERR_BITS = 16;

  localparam logic [15:0] CODE_SPEED = 16'h84F0;
  localparam logic [15:0] CODE_TRACK = 16'h8611;
  localparam logic [15:0] CODE_OVER = 16'h3210;
  localparam logic [15:0] CODE_UNDER = 16'h3220;
  localparam logic [15:0] CODE_CLAMP = 16'h2310;
  localparam logic [15:0] CODE_THERM = 16'h4310;
  localparam logic [15:0] CODE_OVERRUN = 16'h8110;
  localparam logic [15:0] CODE_GUARD = 16'h8130;
  localparam logic [15:0] CODE_BUSOFF = 16'h8141;
  localparam logic [15:0] CODE_PDO = 16'h8210;
  localparam logic [15:0] CODE_NONE = 16'h0000;

  localparam logic [1:0] RESP_NONE = 2'h0;
  localparam logic [1:0] RESP_FAULT = 2'h1;
  localparam logic [1:0] RESP_SOD = 2'h2;
  localparam logic [1:0] RESP_QSTOP = 2'h3;
  localparam logic [15:0] RESP_MAX = 16'h0003;

  localparam logic [1:0] RST_COM_RESP = 2'h1;
  localparam logic RST_MON_EN = 1'b1;
  localparam logic [15:0] RST_MASK = 16'h0000;
  localparam logic [15:0] FAULT_OPT_OFF = 16'h0000;
  localparam logic [15:0] RST_QS_OPT = 16'h0002;
  localparam logic [15:0] QS_HOLD_MIN = 16'h0005;

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic speed_gap_fault;
    logic tracking_gap_fault;
    logic supply_over_limit;
    logic supply_under_limit;
    logic current_setpoint_clamped;
    logic thermal_shutdown_fault;
  } diag_faults_t;

  typedef struct packed {
    logic bus_off;
    logic guard_fail;
    logic pdo_len_bad;
    logic rx_overflow;
    logic op_state_left;
  } com_faults_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [15:0] index;
    logic [7:0] sub;
    logic [15:0] wdata;
  } obj_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } obj_rsp_t;

  typedef struct packed {
    logic brake_on;
    logic ramp_stop;
    logic stage_off;
    logic hold_zero;
    logic jobs_discard;
    logic fault_state;
    logic sod_state;
    logic qs_state;
  } act_t;

  typedef enum logic [2:0] {
    ST_RUN, ST_FAULT_STOP, ST_FAULT, ST_SOD, ST_QS_BRAKE, ST_QS_HOLD, ST_QS_OFF
  } react_state_t;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] err_code(input int idx, input logic [15:0] com_code);
    case (idx)
      BIT_SPEED: err_code = CODE_SPEED;
      BIT_TRACK: err_code = CODE_TRACK;
      BIT_OVER: err_code = CODE_OVER;
      BIT_UNDER: err_code = CODE_UNDER;
      BIT_CLAMP: err_code = CODE_CLAMP;
      BIT_THERM: err_code = CODE_THERM;
      BIT_COM: err_code = com_code;
      default: err_code = CODE_NONE;
    endcase
  endfunction

endpackage

// >>> fault_sync.sv
/*
  Three-stage synchroniser for fault pins; an output bit changes only once
  the second and third stages agree. Assumes levels from foreign domains.
*/
module fault_sync
  import drive_err_pkg::*;
#(
  parameter int WIDTH = 12
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] levels
);

  generate
    if (WIDTH < 1)
    begin : g_bad
      $error("fault_sync needs WIDTH of at least 1");
    end
  endgenerate

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } sync_st_t;

  sync_st_t r;
  sync_st_t n;
  logic [WIDTH-1:0] agree;

  always_comb
  begin
    n = r;
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    // Filters a one-cycle glitch that slipped past the first stage
    agree = ~(r.s2 ^ r.s3);
    n.lvl = (r.s2 & agree) | (r.lvl & ~agree);
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else if (clk_en)
      r <= n;
  end

  assign levels = r.lvl;

endmodule

// >>> emcy_sender.sv
/*
  Emergency message source: each newly raised error bit queues one message
  carrying its code. Assumes the consumer holds emcy_ready as a level.
*/
module emcy_sender
  import drive_err_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [15:0] err_word,
  input wire logic [15:0] com_code,
  input wire logic emcy_ready,
  output logic emcy_valid,
  output logic [15:0] emcy_code
);

  typedef struct packed {
    logic [15:0] prev;
    logic [15:0] pend;
    logic valid;
    logic [15:0] code;
  } emcy_st_t;

  emcy_st_t r;
  emcy_st_t n;
  logic [15:0] take;

  always_comb
  begin
    n = r;
    take = '0;
    if (r.valid && emcy_ready)
      n.valid = 1'b0;
    if (!r.valid)
    begin
      // Lowest bit first; bit 0 outranks the rest
      for (int i = ERR_BITS - 1; i >= 0; i--)
      begin
        if (r.pend[i])
        begin
          take = '0;
          take[i] = 1'b1;
          n.code = err_code(i, com_code);
        end
      end
      n.valid = |r.pend;
    end
    // A new rise in the same cycle as the take keeps its request
    n.pend = (r.pend & ~take) | (err_word & ~r.prev);
    n.prev = err_word;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else if (clk_en)
      r <= n;
  end

  assign emcy_valid = r.valid;
  assign emcy_code = r.code;

  property p_emcy_first;
    @(posedge clk_sys) disable iff (!arst_n)
    clk_en && !r.valid && r.pend[BIT_SPEED] |=> r.valid && r.code == CODE_SPEED;
  endproperty
  a_emcy_first: assert property (p_emcy_first) else $error("speed code not sent first");

endmodule

// >>> drive_error_handling.sv
/*
  Error handling unit of a drive: builds the error word from fault sources,
  serves the related objects over the object access port, and runs the
  reaction to fieldbus faults and device errors. Assumes the motion core
  obeys the act outputs and reports standstill on motor_stopped.
*/
module drive_error_handling
  import drive_err_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire diag_faults_t diag_in,
  input wire com_faults_t com_in,
  input wire logic motor_stopped,
  input wire logic restart_cmd,
  input wire obj_req_t obj_req,
  output obj_rsp_t obj_rsp,
  input wire logic emcy_ready,
  output logic emcy_valid,
  output logic [15:0] emcy_code,
  output logic [15:0] err_word,
  output act_t act
);

  localparam int SYNC_W = $bits(diag_faults_t) + $bits(com_faults_t) + 1;

  typedef struct packed {
    react_state_t state;
    logic [15:0] err_word;
    logic [15:0] com_code;
    logic [1:0] com_resp;
    logic mon_en;
    logic [15:0] mask;
    logic [15:0] fault_opt;
    logic [15:0] qs_opt;
    logic prof_prev;
    obj_rsp_t rsp;
    act_t act;
  } st_t;

  localparam st_t ST_RST = '{
    state: ST_RUN,
    err_word: 16'h0000,
    com_code: CODE_NONE,
    com_resp: RST_COM_RESP,
    mon_en: RST_MON_EN,
    mask: RST_MASK,
    fault_opt: FAULT_OPT_OFF,
    qs_opt: RST_QS_OPT,
    prof_prev: 1'b0,
    rsp: '0,
    act: '0
  };

  function automatic logic obj_hit(input obj_req_t q, input logic [15:0] idx, input logic [7:0] sub);
    obj_hit = (q.index == idx) && (q.sub == sub);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  st_t r;
  st_t n;
  logic [SYNC_W-1:0] sync_lvl;
  diag_faults_t ds;
  com_faults_t cs;
  logic stopped_s;
  logic com_err;
  logic prof_lvl;
  logic com_trig;
  logic dev_fault;

  fault_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .pins({diag_in, com_in, motor_stopped}),
    .levels(sync_lvl)
  );

  assign {ds, cs, stopped_s} = sync_lvl;

  ////////////////////////////////////////////////////////////////////////
  // Fault classification
  // Only supervised buses count at all
  assign com_err = r.mon_en & (cs.pdo_len_bad | cs.rx_overflow | cs.bus_off | cs.guard_fail);
  assign prof_lvl = r.mon_en & (cs.bus_off | cs.guard_fail | cs.op_state_left);
  assign com_trig = prof_lvl & ~r.prof_prev;
  // Overvoltage and over-temperature always switch off, whatever the mask
  assign dev_fault = (|(r.err_word & r.mask)) | r.err_word[BIT_OVER] | r.err_word[BIT_THERM];

  always_comb
  begin
    n = r;
    n.rsp.ack = 1'b0;
    n.rsp.err = 1'b0;
    n.act.jobs_discard = 1'b0;

    // Error word follows the current levels; nothing latches here
    n.err_word = '0;
    n.err_word[BIT_SPEED] = ds.speed_gap_fault;
    n.err_word[BIT_TRACK] = ds.tracking_gap_fault;
    n.err_word[BIT_OVER] = ds.supply_over_limit;
    n.err_word[BIT_UNDER] = ds.supply_under_limit;
    n.err_word[BIT_CLAMP] = ds.current_setpoint_clamped;
    n.err_word[BIT_THERM] = ds.thermal_shutdown_fault;
    n.err_word[BIT_COM] = com_err;

    // Code of the most serious bus cause present
    if (cs.bus_off)
      n.com_code = CODE_BUSOFF;
    else if (cs.guard_fail)
      n.com_code = CODE_GUARD;
    else if (cs.rx_overflow)
      n.com_code = CODE_OVERRUN;
    else if (cs.pdo_len_bad)
      n.com_code = CODE_PDO;

    // Edge only: a persisting bus fault reacts once
    n.prof_prev = prof_lvl;

    //////////////////////////////////////////////////////////////////////
    // Reaction state machine
    if (dev_fault && r.state != ST_FAULT)
      n.state = ST_FAULT;
    else
    begin
      case (r.state)
        ST_RUN:
        begin
          if (com_trig)
          begin
            case (r.com_resp)
              RESP_NONE: n.state = ST_RUN;
              RESP_FAULT: n.state = (r.fault_opt != FAULT_OPT_OFF) ? ST_FAULT_STOP : ST_FAULT;
              RESP_SOD: n.state = ST_SOD;
              default:
              begin
                n.state = ST_QS_BRAKE;
                n.act.jobs_discard = 1'b1;
              end
            endcase
          end
        end
        ST_FAULT_STOP:
        begin
          if (stopped_s)
            n.state = ST_FAULT;
        end
        ST_FAULT:
        begin
          if (restart_cmd && !dev_fault && !prof_lvl)
            n.state = ST_SOD;
        end
        ST_SOD:
        begin
          if (restart_cmd && !prof_lvl)
            n.state = ST_RUN;
        end
        ST_QS_BRAKE:
        begin
          if (stopped_s)
            n.state = (r.qs_opt >= QS_HOLD_MIN) ? ST_QS_HOLD : ST_QS_OFF;
        end
        ST_QS_HOLD, ST_QS_OFF:
        begin
          if (restart_cmd)
            n.state = ST_SOD;
        end
        default: n.state = ST_FAULT;
      endcase
    end

    // Outputs follow the state about to be entered
    // Coasting states never ramp; the brake closes once the stage is off
    n.act.ramp_stop = (n.state == ST_FAULT_STOP) || (n.state == ST_QS_BRAKE);
    n.act.stage_off = (n.state == ST_FAULT) || (n.state == ST_SOD) || (n.state == ST_QS_OFF);
    n.act.brake_on = n.act.stage_off;
    n.act.hold_zero = (n.state == ST_QS_HOLD);
    n.act.fault_state = (n.state == ST_FAULT_STOP) || (n.state == ST_FAULT);
    n.act.sod_state = (n.state == ST_SOD);
    n.act.qs_state = (n.state == ST_QS_BRAKE) || (n.state == ST_QS_HOLD) || (n.state == ST_QS_OFF);

    //////////////////////////////////////////////////////////////////////
    // Object access; every request gets one ack the next cycle
    if (obj_req.valid)
    begin
      n.rsp.ack = 1'b1;
      n.rsp.rdata = '0;
      if (obj_hit(obj_req, OBJ_ERR_WORD, SUB_MAIN))
      begin
        if (obj_req.we)
          n.rsp.err = 1'b1;
        else
          n.rsp.rdata = r.err_word;
      end
      else if (obj_hit(obj_req, OBJ_ERR_MASK, SUB_MAIN))
      begin
        if (obj_req.we)
          n.mask = obj_req.wdata;
        else
          n.rsp.rdata = r.mask;
      end
      else if (obj_hit(obj_req, OBJ_COM_RESP, SUB_MAIN))
      begin
        if (obj_req.we && obj_req.wdata > RESP_MAX)
          n.rsp.err = 1'b1;
        else if (obj_req.we)
          n.com_resp = obj_req.wdata[1:0];
        else
          n.rsp.rdata = {14'h0000, r.com_resp};
      end
      else if (obj_hit(obj_req, OBJ_COM_CFG, SUB_MON))
      begin
        if (obj_req.we)
          n.mon_en = obj_req.wdata[0];
        else
          n.rsp.rdata = {15'h0000, r.mon_en};
      end
      else if (obj_hit(obj_req, OBJ_FAULT_OPT, SUB_MAIN))
      begin
        if (obj_req.we)
          n.fault_opt = obj_req.wdata;
        else
          n.rsp.rdata = r.fault_opt;
      end
      else if (obj_hit(obj_req, OBJ_QS_OPT, SUB_MAIN))
      begin
        if (obj_req.we)
          n.qs_opt = obj_req.wdata;
        else
          n.rsp.rdata = r.qs_opt;
      end
      else
        n.rsp.err = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      r <= ST_RST;
    else if (clk_en)
      r <= n;
  end

  ////////////////////////////////////////////////////////////////////////
  emcy_sender u_emcy (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .err_word(r.err_word),
    .com_code(r.com_code),
    .emcy_ready(emcy_ready),
    .emcy_valid(emcy_valid),
    .emcy_code(emcy_code)
  );

  assign obj_rsp = r.rsp;
  assign err_word = r.err_word;
  assign act = r.act;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_run_trig;
    clk_en && r.state == ST_RUN && com_trig && !dev_fault;
  endsequence

  sequence s_qs_trig;
    s_run_trig ##0 r.com_resp == RESP_QSTOP;
  endsequence

  property p_resp_write;
    @(posedge clk_sys) disable iff (!arst_n)
    clk_en && obj_req.valid && obj_req.we && obj_hit(obj_req, OBJ_COM_RESP, SUB_MAIN) && obj_req.wdata <= RESP_MAX
    |=> {14'h0000, r.com_resp} == $past(obj_req.wdata) && r.rsp.ack && !r.rsp.err;
  endproperty
  a_resp_write: assert property (p_resp_write) else $error("response selection not stored");

  property p_resp_none;
    @(posedge clk_sys) disable iff (!arst_n)
    s_run_trig ##0 r.com_resp == RESP_NONE |=> r.state == ST_RUN && !r.act.ramp_stop;
  endproperty
  a_resp_none: assert property (p_resp_none) else $error("response 0 changed the drive state");

  property p_resp_fault;
    @(posedge clk_sys) disable iff (!arst_n)
    s_run_trig ##0 r.com_resp == RESP_FAULT
    |=> r.act.fault_state && (r.act.ramp_stop == ($past(r.fault_opt) != FAULT_OPT_OFF));
  endproperty
  a_resp_fault: assert property (p_resp_fault) else $error("response 1 did not enter fault");

  property p_resp_sod;
    @(posedge clk_sys) disable iff (!arst_n)
    s_run_trig ##0 r.com_resp == RESP_SOD |=> r.act.sod_state && r.act.stage_off && r.act.brake_on && !r.act.ramp_stop;
  endproperty
  a_resp_sod: assert property (p_resp_sod) else $error("response 2 did not coast");

  property p_resp_qs;
    @(posedge clk_sys) disable iff (!arst_n)
    s_qs_trig |=> r.act.qs_state && r.act.jobs_discard && r.act.ramp_stop;
  endproperty
  a_resp_qs: assert property (p_resp_qs) else $error("response 3 did not quick-stop");

  property p_qs_end;
    @(posedge clk_sys) disable iff (!arst_n)
    clk_en && r.state == ST_QS_BRAKE && stopped_s && !dev_fault
    |=> (r.act.hold_zero != r.act.stage_off) && (r.act.hold_zero == ($past(r.qs_opt) >= QS_HOLD_MIN));
  endproperty
  a_qs_end: assert property (p_qs_end) else $error("quick-stop end action wrong");

  property p_mon_off;
    @(posedge clk_sys) disable iff (!arst_n)
    clk_en && !r.mon_en |=> !r.err_word[BIT_COM] && !$past(com_trig);
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("unmonitored bus reported a fault");

  property p_word_only;
    @(posedge clk_sys) disable iff (!arst_n)
    clk_en && r.mon_en && (cs.pdo_len_bad || cs.rx_overflow) && r.state == ST_RUN && !prof_lvl && !dev_fault
    |=> r.err_word[BIT_COM] && r.state == ST_RUN;
  endproperty
  a_word_only: assert property (p_word_only) else $error("word-only fault misrouted");

  property p_prof_only;
    @(posedge clk_sys) disable iff (!arst_n)
    clk_en && r.mon_en && cs.op_state_left && !cs.bus_off && !cs.guard_fail && !cs.pdo_len_bad && !cs.rx_overflow
    |=> !r.err_word[BIT_COM];
  endproperty
  a_prof_only: assert property (p_prof_only) else $error("state loss reached the error word");

  property p_mask_fault;
    @(posedge clk_sys) disable iff (!arst_n)
    clk_en && |(r.err_word & r.mask) |=> r.act.fault_state && r.act.stage_off;
  endproperty
  a_mask_fault: assert property (p_mask_fault) else $error("masked error gave no reaction");

  property p_over_off;
    @(posedge clk_sys) disable iff (!arst_n)
    clk_en && r.err_word[BIT_OVER] |=> r.act.stage_off && r.act.fault_state;
  endproperty
  a_over_off: assert property (p_over_off) else $error("overvoltage did not switch off");

  property p_therm_off;
    @(posedge clk_sys) disable iff (!arst_n)
    clk_en && r.err_word[BIT_THERM] |=> r.act.stage_off && r.act.brake_on;
  endproperty
  a_therm_off: assert property (p_therm_off) else $error("temperature limit did not switch off");

  property p_bit_follow;
    @(posedge clk_sys) disable iff (!arst_n)
    clk_en && !ds.tracking_gap_fault && ds.speed_gap_fault |=> !r.err_word[BIT_TRACK] && r.err_word[BIT_SPEED];
  endproperty
  a_bit_follow: assert property (p_bit_follow) else $error("error bits do not follow levels");

  property p_supply_bits;
    @(posedge clk_sys) disable iff (!arst_n)
    clk_en && ds.supply_under_limit && !ds.current_setpoint_clamped |=> r.err_word[BIT_UNDER] && !r.err_word[BIT_CLAMP];
  endproperty
  a_supply_bits: assert property (p_supply_bits) else $error("undervoltage or clamp bit wrong");

endmodule

// >>> bus_master_model.sv
/*
  Fieldbus master model: object accesses and the emergency consumer.
  Assumes the unit's object port takes a one-cycle valid and acks after one cycle.
*/
module bus_master_model
  import drive_err_pkg::*;
(
  input wire logic clk_sys,
  output obj_req_t obj_req,
  input wire obj_rsp_t obj_rsp,
  input wire logic emcy_valid,
  input wire logic [15:0] emcy_code,
  output logic emcy_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic slow = 1'b0;
  logic [1:0] phase = 2'h0;
  logic [15:0] last_code = 16'h0000;
  initial
  begin
    obj_req = '0;
    emcy_ready = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Slow consumer takes a message only every fourth cycle
  always @(posedge clk_sys)
  begin
    phase <= phase + 2'h1;
    emcy_ready <= !slow || (phase == 2'h3);
    if (emcy_valid === 1'b1 && emcy_ready)
      last_code <= emcy_code;
  end
  // Master owns the response selection object
  task automatic access(input logic we, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [15:0] wd, output obj_rsp_t rsp);
    int n;
    obj_req <= '{1'b1, we, idx, sub, wd};
    @(posedge clk_sys);
    // Released fields show the inverse, not a stale copy
    obj_req <= '{1'b0, ~we, ~idx, ~sub, ~wd};
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (obj_rsp.ack !== 1'b1 && n < 4);
    rsp = obj_rsp;
  endtask
endmodule

// >>> tb_drive_error_handling.sv
/*
  Self-checking bench for the drive error handling unit.
  Assumes the unit and the master model share clk_sys; clock enable held high.
*/
module tb_drive_error_handling
  import drive_err_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic arst_n;
  diag_faults_t diag_in;
  com_faults_t com_in;
  logic motor_stopped;
  logic restart_cmd;
  obj_req_t obj_req;
  obj_rsp_t obj_rsp;
  logic emcy_ready;
  logic emcy_valid;
  logic [15:0] emcy_code;
  logic [15:0] err_word;
  act_t act;
  int num_errors = 0;
  int num_checks = 0;
  logic seen_discard = 1'b0;
  logic [15:0] codes [6] = '{CODE_SPEED, CODE_TRACK, CODE_OVER, CODE_UNDER, CODE_CLAMP, CODE_THERM};
  logic [7:0] exp_hit [6] = '{8'h00, 8'hA4, 8'hA2, 8'h41, 8'h44, 8'h41};
  logic [7:0] exp_stop [6] = '{8'h00, 8'hA4, 8'hA2, 8'hA1, 8'hA4, 8'h11};
  logic [15:0] resp_sel [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0001, 16'h0003};

  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (act.jobs_discard === 1'b1)
      seen_discard <= 1'b1;

  drive_error_handling dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(1'b1), .diag_in(diag_in),
    .com_in(com_in), .motor_stopped(motor_stopped), .restart_cmd(restart_cmd), .obj_req(obj_req),
    .obj_rsp(obj_rsp), .emcy_ready(emcy_ready), .emcy_valid(emcy_valid), .emcy_code(emcy_code),
    .err_word(err_word), .act(act));
  bus_master_model master (.clk_sys(clk_sys), .obj_req(obj_req), .obj_rsp(obj_rsp),
    .emcy_valid(emcy_valid), .emcy_code(emcy_code), .emcy_ready(emcy_ready));

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] exp);
    obj_rsp_t r;
    master.access(1'b0, idx, sub, 16'h0000, r);
    check16({14'h0000, r.ack, r.err}, 16'h0002, "read status");
    check16(r.rdata, exp, "read data");
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] d, input logic e);
    obj_rsp_t r;
    master.access(1'b1, idx, sub, d, r);
    check16({14'h0000, r.ack, r.err}, {14'h0000, 1'b1, e}, "write status");
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Restart twice: fault leaves through switch-on-disabled
  task automatic restart();
    repeat (2)
    begin
      restart_cmd <= 1'b1;
      @(posedge clk_sys);
      restart_cmd <= 1'b0;
      wait_cyc(2);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #500000;
    num_errors++;
    print_verdict();
  end
  initial
  begin
    arst_n = 1'b0;
    diag_in = '0;
    com_in = '0;
    motor_stopped = 1'b0;
    restart_cmd = 1'b0;
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rd(OBJ_COM_RESP, SUB_MAIN, 16'h0001);
    rd(OBJ_COM_CFG, SUB_MON, 16'h0001);
    rd(OBJ_ERR_WORD, SUB_MAIN, 16'h0000);
    wr(OBJ_ERR_WORD, SUB_MAIN, 16'h0001, 1'b1);
    wr(OBJ_COM_RESP, SUB_MAIN, 16'h0004, 1'b1);
    wr(16'h1234, SUB_MAIN, 16'h0000, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      diag_in <= diag_faults_t'(6'h20 >> i);
      wait_cyc(10);
      check16(err_word, 16'h0001 << i, "error word");
      check16(master.last_code, codes[i], "emergency code");
      check16({15'h0000, act.fault_state}, {15'h0000, i == 2 || i == 5}, "switch off");
      diag_in <= '0;
      wait_cyc(8);
      check16(err_word, 16'h0000, "error word clear");
      restart();
    end
    wr(OBJ_ERR_MASK, SUB_MAIN, 16'h0001, 1'b0);
    diag_in <= diag_faults_t'(6'h20);
    wait_cyc(8);
    check16({15'h0000, act.fault_state}, 16'h0001, "masked reaction");
    diag_in <= '0;
    wr(OBJ_ERR_MASK, SUB_MAIN, 16'h0000, 1'b0);
    wait_cyc(8);
    restart();
    // Slow consumer here: messages must wait, not drop
    master.slow <= 1'b1;
    for (int s = 0; s < 6; s++)
    begin
      // Last two rounds: controlled stop before fault, hold after quick-stop
      if (s == 4)
      begin
        wr(OBJ_FAULT_OPT, SUB_MAIN, 16'h0001, 1'b0);
        wr(OBJ_QS_OPT, SUB_MAIN, QS_HOLD_MIN, 1'b0);
      end
      wr(OBJ_COM_RESP, SUB_MAIN, resp_sel[s], 1'b0);
      seen_discard <= 1'b0;
      com_in.bus_off <= 1'b1;
      wait_cyc(12);
      check16(err_word, 16'h0800, "bus off word");
      check16(master.last_code, CODE_BUSOFF, "bus off code");
      check16({8'h00, act}, {8'h00, exp_hit[s]}, "reaction");
      check16({15'h0000, seen_discard}, {15'h0000, s == 3 || s == 5}, "jobs dropped");
      motor_stopped <= 1'b1;
      wait_cyc(8);
      check16({8'h00, act}, {8'h00, exp_stop[s]}, "after standstill");
      com_in <= '0;
      motor_stopped <= 1'b0;
      wait_cyc(8);
      restart();
    end
    wr(OBJ_COM_RESP, SUB_MAIN, 16'h0001, 1'b0);
    wr(OBJ_FAULT_OPT, SUB_MAIN, 16'h0000, 1'b0);
    wr(OBJ_COM_CFG, SUB_MON, 16'h0000, 1'b0);
    com_in.bus_off <= 1'b1;
    wait_cyc(10);
    check16(err_word, 16'h0000, "unmonitored word");
    check16({8'h00, act}, 16'h0000, "unmonitored reaction");
    com_in <= '0;
    // Let the synchroniser drain, or re-enabling sees a stale bus fault
    wait_cyc(8);
    wr(OBJ_COM_CFG, SUB_MON, 16'h0001, 1'b0);
    com_in.pdo_len_bad <= 1'b1;
    wait_cyc(10);
    check16(err_word, 16'h0800, "length fault word");
    check16({8'h00, act}, 16'h0000, "length fault reaction");
    com_in <= com_faults_t'(5'h01);
    wait_cyc(10);
    check16(err_word, 16'h0000, "state left word");
    check16({8'h00, act}, 16'h00A4, "state left reaction");
    com_in <= '0;
    wait_cyc(8);
    restart();
    print_verdict();
  end
endmodule
